// File: rtl/asf_alu.sv
// Arithmetic unit that computes result and five flags
`timescale 1ns/10ps
`include "asf_defines.svh"
module asf_alu (
    asf_alu_if.unit alu
);
    import asf_pkg::*;
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] bn;
    logic add_like;
    always_comb begin
        bn = ~alu.b;
        add_like = (alu.op == ASF_OP_ADD) || (alu.op == ASF_OP_SUB);
        unique case (alu.op)
            ASF_OP_ADD: begin
                full = {1'b0, alu.a} + {1'b0, alu.b};
                low = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
            end
            ASF_OP_SUB: begin
                // Carry out of a + ~b + 1 doubles as "no borrow" [RQ5]
                full = {1'b0, alu.a} + {1'b0, bn} + 9'h001;
                low = {1'b0, alu.a[3:0]} + {1'b0, bn[3:0]} + 5'h01;
            end
            ASF_OP_LOGIC: begin
                full = {1'b0, alu.a & alu.b};
                low = 5'h00;
            end
            default: begin
                full = 9'h000;
                low = 5'h00;
            end
        endcase
        alu.result = full[7:0];
        alu.flags[`ASF_BIT_CARRY] = add_like & full[8]; // [RQ5]
        alu.flags[`ASF_BIT_NIBBLE] = add_like & low[4]; // [RQ5]
        alu.flags[`ASF_BIT_ZERO] = (full[7:0] == `ASF_ZERO_BYTE); // [RQ7]
        alu.flags[`ASF_BIT_WRAP] = add_like & // [RQ6]
            (alu.a[7] == (alu.op == ASF_OP_SUB ? bn[7] : alu.b[7])) & (full[7] != alu.a[7]);
        alu.flags[`ASF_BIT_MSB] = full[7]; // [RQ8]
    end
endmodule : asf_alu

// File: rtl/asf_alu_if.sv
// Carrier between flag register and its arithmetic unit
`timescale 1ns/10ps
interface asf_alu_if;
    import asf_pkg::*;
    asf_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] result;
    logic [4:0] flags;
    modport core (output op, output a, output b, input result, input flags);
    modport unit (input op, input a, input b, output result, output flags);
endinterface : asf_alu_if

// File: rtl/asf_defines.svh
// Constants of the arithmetic status flag register
`ifndef ASF_DEFINES_SVH
`define ASF_DEFINES_SVH
`define ASF_DATA_W 8
`define ASF_BIT_CARRY 0
`define ASF_BIT_NIBBLE 1
`define ASF_BIT_ZERO 2
`define ASF_BIT_WRAP 3
`define ASF_BIT_MSB 4
`define ASF_FLAG_MASK 8'h1F
`define ASF_MASK_RESET 5'h1F
`define ASF_RESET_VAL 8'h00
`define ASF_ZERO_BYTE 8'h00
`define ASF_APB_STATUS 12'h000
`define ASF_APB_LAST 12'h004
`define ASF_APB_MASK 12'h008
`endif

// File: rtl/asf_pkg.sv
// Types of the arithmetic status flag register
package asf_pkg;
    typedef enum logic [2:0] {
        ASF_OP_NONE,
        ASF_OP_ADD,
        ASF_OP_SUB,
        ASF_OP_LOGIC,
        ASF_OP_CLEAR
    } asf_op_t;
endpackage : asf_pkg

// File: rtl/asf_status.sv
// Arithmetic status flag register with operand access and APB view
// Summary of operation
// RQ1: Status register usable as any operand; the code routes it only to operand a and as write destination
// RQ2: Flag logic overrides writes to flag bits
// RQ3: Clear on status sets only zero flag
// RQ4: Software alters status with flag-neutral ops
// RQ5: Subtraction carries act as borrows
// RQ6: Signed overflow sets wrap flag
// RQ7: Zero result sets zero flag
// RQ8: Msb flag follows bit 7; top bits zero
`timescale 1ns/10ps
`include "asf_defines.svh"
module asf_status (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Instruction side
    input wire logic exec_in,
    input wire asf_pkg::asf_op_t op_in,
    input wire logic [7:0] opa_in,
    input wire logic [7:0] opb_in,
    input wire logic src_is_status_in,
    input wire logic dst_is_status_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] result_out,
    output logic [7:0] status_out,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out
);
    import asf_pkg::*;
    asf_alu_if alu_bus ();
    asf_alu u_alu (.alu(alu_bus));

    logic [7:0] status_r, status_nxt;
    logic [7:0] result_r, result_nxt;
    logic [7:0] last_r, last_nxt;
    logic [4:0] mask_r, mask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [7:0] opa;
    logic flag_op;

    // ****************************************
    // Helpers
    // ****************************************
    // Setup phase of an APB transfer
    function automatic logic apb_setup(input logic sel, input logic en);
        return sel && !en;
    endfunction : apb_setup

    // Access phase of an APB transfer
    function automatic logic apb_access(input logic sel, input logic en);
        return sel && en;
    endfunction : apb_access

    // Masked bits take fresh flags; the rest keep old ones
    function automatic logic [7:0] merge_flags(input logic [7:0] old, input logic [4:0] fresh,
                                               input logic [4:0] mask);
        return {3'b000, fresh & mask} | (old & ~{3'b000, mask});
    endfunction : merge_flags

    // ****************************************
    // Instruction datapath
    // ****************************************
    always_comb begin
        // Status readable as source operand [RQ1]
        opa = src_is_status_in ? status_r : opa_in;
        alu_bus.op = (op_in == ASF_OP_CLEAR) ? ASF_OP_NONE : op_in;
        alu_bus.a = opa;
        alu_bus.b = opb_in;
        flag_op = exec_in && (op_in != ASF_OP_NONE);
        status_nxt = status_r;
        result_nxt = result_r;
        last_nxt = last_r;
        if (exec_in) begin
            unique case (op_in)
                ASF_OP_CLEAR: result_nxt = `ASF_ZERO_BYTE;
                ASF_OP_NONE: result_nxt = opa;
                default: result_nxt = alu_bus.result;
            endcase
            last_nxt = result_nxt;
            // Plain writes to status land only in writable bits [RQ1]
            if (wr_in && dst_is_status_in) begin
                status_nxt = wdata_in & `ASF_FLAG_MASK;
            end
        end
        if (flag_op) begin
            if (op_in == ASF_OP_CLEAR) begin
                // Only zero flag moves; the rest keep old value [RQ3]
                status_nxt = status_r;
                status_nxt[`ASF_BIT_ZERO] = 1'b1;
            end else begin
                // Flag logic wins over the data write [RQ2]
                status_nxt = merge_flags(status_r, alu_bus.flags, mask_r);
            end
        end
        status_nxt = status_nxt & `ASF_FLAG_MASK; // [RQ8]
    end

    // ****************************************
    // APB slave, zero wait states
    // ****************************************
    always_comb begin
        mask_nxt = mask_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        pready_nxt = apb_setup(psel_in, penable_in);
        if (apb_setup(psel_in, penable_in)) begin
            prdata_nxt = 32'h0000_0000;
            unique case (paddr_in)
                `ASF_APB_STATUS: prdata_nxt = {24'h00_0000, status_r};
                `ASF_APB_LAST: prdata_nxt = {24'h00_0000, last_r};
                `ASF_APB_MASK: prdata_nxt = {27'h000_0000, mask_r};
                default: pslverr_nxt = 1'b1;
            endcase
        end
        // Write commits at the access edge with pready high
        if (apb_access(psel_in, penable_in) && pready_r && pwrite_in &&
                paddr_in == `ASF_APB_MASK) begin
            mask_nxt = pwdata_in[`ASF_BIT_MSB:`ASF_BIT_CARRY];
        end
    end

    // ****************************************
    // Instruction state registers
    // ****************************************
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_r <= `ASF_RESET_VAL;
            result_r <= `ASF_RESET_VAL;
            last_r <= `ASF_RESET_VAL;
        end else begin
            status_r <= status_nxt;
            result_r <= result_nxt;
            last_r <= last_nxt;
        end
    end

    // ****************************************
    // APB state registers
    // ****************************************
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mask_r <= `ASF_MASK_RESET;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            mask_r <= mask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    always_comb begin
        status_out = status_r;
        result_out = result_r;
        prdata_out = prdata_r;
        pready_out = pready_r;
        pslverr_out = pslverr_r;
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_clear_status;
        exec_in && op_in == ASF_OP_CLEAR;
    endsequence

    a_clear_sets_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ3]
        s_clear_status |=> status_r[`ASF_BIT_ZERO] &&
            status_r[1:0] == $past(status_r[1:0]) && status_r[4:3] == $past(status_r[4:3]))
        else $error("clear did not leave 000u uluu");
    a_top_bits_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ8]
        status_out[7:5] == 3'b000)
        else $error("status top bits not zero");
    a_zero_flag_ok: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ7]
        exec_in && op_in == ASF_OP_ADD && mask_r[`ASF_BIT_ZERO]
        |=> status_r[`ASF_BIT_ZERO] == (result_r == 8'h00))
        else $error("zero flag wrong");
    a_msb_follows: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ8]
        exec_in && op_in == ASF_OP_LOGIC && mask_r[`ASF_BIT_MSB]
        |=> status_r[`ASF_BIT_MSB] == result_r[7])
        else $error("msb flag wrong");
    a_flags_beat_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ2]
        exec_in && wr_in && dst_is_status_in && op_in == ASF_OP_ADD && mask_r == 5'h1F
        |=> status_r[4:0] == $past(alu_bus.flags))
        else $error("data write reached flags");
    a_sub_borrow: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ5]
        exec_in && op_in == ASF_OP_SUB && mask_r[0] && !src_is_status_in
        |=> status_r[0] == ($past(opa_in) >= $past(opb_in)))
        else $error("borrow sense wrong");
    a_wrap_flag: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ6]
        exec_in && op_in == ASF_OP_ADD && mask_r[3] && !src_is_status_in
        |=> status_r[3] == ($past(opa_in[7]) == $past(opb_in[7]) &&
            result_r[7] != $past(opa_in[7])))
        else $error("overflow flag wrong");
    a_source_status: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ1]
        exec_in && op_in == ASF_OP_NONE && src_is_status_in |=> result_r == $past(status_r))
        else $error("status not usable as source");
    a_apb_ready: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        psel_in && !penable_in |=> pready_out)
        else $error("apb ready late");

    // ****************************************
    // Flag checks
    // ****************************************
    // Full mask, and plain operands for add and sub, so flags are predictable
    sequence s_full_add;
        exec_in && op_in == ASF_OP_ADD && mask_r == `ASF_MASK_RESET && !src_is_status_in;
    endsequence

    sequence s_full_sub;
        exec_in && op_in == ASF_OP_SUB && mask_r == `ASF_MASK_RESET && !src_is_status_in;
    endsequence

    sequence s_full_logic;
        exec_in && op_in == ASF_OP_LOGIC && mask_r == `ASF_MASK_RESET;
    endsequence

    a_add_carry: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ2]
        s_full_add |=> status_r[`ASF_BIT_CARRY] ==
            ({1'b0, $past(opa_in)} + {1'b0, $past(opb_in)} > 9'h0FF))
        else $error("add carry wrong");
    a_add_nibble: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ2]
        s_full_add |=> status_r[`ASF_BIT_NIBBLE] ==
            ({1'b0, $past(opa_in[3:0])} + {1'b0, $past(opb_in[3:0])} > 5'h0F))
        else $error("add nibble carry wrong");
    a_add_msb: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ8]
        s_full_add |=> status_r[`ASF_BIT_MSB] == result_r[7])
        else $error("add msb flag wrong");
    a_sub_nibble: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ5]
        s_full_sub |=> status_r[`ASF_BIT_NIBBLE] ==
            ($past(opa_in[3:0]) >= $past(opb_in[3:0])))
        else $error("digit borrow sense wrong");
    a_sub_wrap: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ6]
        s_full_sub |=> status_r[`ASF_BIT_WRAP] == ($past(opa_in[7]) != $past(opb_in[7]) &&
            result_r[7] != $past(opa_in[7])))
        else $error("subtract overflow flag wrong");
    a_sub_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ7]
        s_full_sub |=> status_r[`ASF_BIT_ZERO] == ($past(opa_in) == $past(opb_in)))
        else $error("subtract zero flag wrong");
    a_sub_msb: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ8]
        s_full_sub |=> status_r[`ASF_BIT_MSB] == result_r[7])
        else $error("subtract msb flag wrong");
    a_logic_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ7]
        s_full_logic |=> status_r[`ASF_BIT_ZERO] == (result_r == `ASF_ZERO_BYTE))
        else $error("logic zero flag wrong");
    a_logic_clears: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ6]
        s_full_logic |=> !status_r[`ASF_BIT_WRAP] && !status_r[`ASF_BIT_NIBBLE] &&
            !status_r[`ASF_BIT_CARRY])
        else $error("logic left arithmetic flags set");

    // ****************************************
    // Write and hold checks
    // ****************************************
    a_clear_result: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ3]
        s_clear_status |=> result_r == `ASF_ZERO_BYTE)
        else $error("clear result not zero");
    a_plain_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ1]
        exec_in && op_in == ASF_OP_NONE && wr_in && dst_is_status_in
        |=> status_r == ($past(wdata_in) & `ASF_FLAG_MASK))
        else $error("plain write to status lost");
    // Flags masked out keep their value even under a data write
    a_masked_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RQ2]
        exec_in && (op_in == ASF_OP_ADD || op_in == ASF_OP_SUB || op_in == ASF_OP_LOGIC)
        |=> (status_r[`ASF_BIT_MSB:`ASF_BIT_CARRY] & ~$past(mask_r)) ==
            ($past(status_r[`ASF_BIT_MSB:`ASF_BIT_CARRY]) & ~$past(mask_r)))
        else $error("masked flag changed");
    a_idle_holds: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        !exec_in |=> $stable(status_r))
        else $error("status moved without an instruction");
    a_last_follows: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        exec_in |=> last_r == result_r)
        else $error("last result copy wrong");

    // ****************************************
    // APB checks
    // ****************************************
    sequence s_apb_setup;
        apb_setup(psel_in, penable_in);
    endsequence

    sequence s_mask_write;
        apb_access(psel_in, penable_in) && pready_out && pwrite_in &&
            paddr_in == `ASF_APB_MASK;
    endsequence

    a_ready_pulse: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        pready_out |=> !pready_out)
        else $error("apb ready held too long");
    a_status_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        s_apb_setup ##0 (paddr_in == `ASF_APB_STATUS)
        |=> prdata_out == {24'h00_0000, $past(status_r)})
        else $error("apb status read wrong");
    a_unmapped_error: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        s_apb_setup ##0 (paddr_in != `ASF_APB_STATUS && paddr_in != `ASF_APB_LAST &&
            paddr_in != `ASF_APB_MASK) |=> pslverr_out && prdata_out == 32'h0000_0000)
        else $error("apb unmapped access not refused");
    a_mask_commit: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        s_mask_write |=> mask_r == $past(pwdata_in[`ASF_BIT_MSB:`ASF_BIT_CARRY]))
        else $error("mask write lost");
endmodule : asf_status

// File: test/asf_core_model.sv
// Core decoder model that issues one instruction at a time
`timescale 1ns/10ps
module asf_core_model (
    // Clock
    input wire logic mclk_in,
    // Instruction side
    output logic exec_out,
    output asf_pkg::asf_op_t op_out,
    output logic [7:0] opa_out,
    output logic [7:0] opb_out,
    output logic [2:0] ctl_out,
    output logic [7:0] wdata_out
);
    import asf_pkg::*;
    initial begin
        exec_out = 1'b0;
        op_out = ASF_OP_NONE;
        opa_out = 8'h00;
        opb_out = 8'h00;
        ctl_out = 3'h0;
        wdata_out = 8'h00;
    end
    // Ctl is {source status, dest status, write}
    task issue(input asf_op_t op, input logic [7:0] a, input logic [7:0] b,
               input logic [2:0] c, input logic [7:0] wd);
        @(posedge mclk_in);
        exec_out <= 1'b1;
        op_out <= op;
        opa_out <= a;
        opb_out <= b;
        ctl_out <= c;
        wdata_out <= wd;
        @(posedge mclk_in);
        exec_out <= 1'b0;
        ctl_out <= 3'h0;
        // Released operands flip so stale values never look valid
        opa_out <= ~a;
        opb_out <= ~b;
    endtask : issue
endmodule : asf_core_model

// File: test/testbench.sv
// Self-checking bench for the status flag register
`timescale 1ns/10ps
module testbench;
    import asf_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, perr;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0000_0000, prd, rd;
    logic exec, er;
    asf_op_t op;
    logic [7:0] a, b, wd, res, stat, st = 8'h00;
    logic [2:0] ctl;
    int err_count = 0, n_compared = 0, cyc = 0;
    always #25 mclk_in = ~mclk_in;
    asf_core_model u_core (.mclk_in(mclk_in), .exec_out(exec), .op_out(op),
        .opa_out(a), .opb_out(b), .ctl_out(ctl), .wdata_out(wd));
    asf_status i_asf_status (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .exec_in(exec),
        .op_in(op), .opa_in(a), .opb_in(b), .src_is_status_in(ctl[2]),
        .dst_is_status_in(ctl[1]), .wr_in(ctl[0]), .wdata_in(wd), .result_out(res),
        .status_out(stat), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(pready),
        .pslverr_out(perr));
    // ****************
    // Checks and tasks
    // ****************
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            give_verdict;
        end
    end
    task ck(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : ck
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1'b1;
        pwr <= w;
        padr <= ad;
        pwd <= d;
        @(posedge mclk_in);
        pen <= 1'b1;
        do @(posedge mclk_in); while (pready !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // Expected flags {msb, wrap, zero, nibble, carry}; carry set means no borrow
    function automatic logic [4:0] fl(asf_op_t o, logic [7:0] x, logic [7:0] y,
                                      logic [4:0] old);
        logic [7:0] yy;
        logic [8:0] s;
        logic [4:0] h;
        yy = (o == ASF_OP_SUB) ? ~y : y;
        s = {1'b0, x} + {1'b0, yy} + {8'h00, o == ASF_OP_SUB};
        h = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, o == ASF_OP_SUB};
        if (o == ASF_OP_CLEAR) return old | 5'h04;
        if (o == ASF_OP_LOGIC) return {(x & y) >= 8'h80, 1'b0, (x & y) == 8'h00, 2'h0};
        return {s[7], x[7] == yy[7] && s[7] != x[7], s[7:0] == 8'h00, h[4], s[8]};
    endfunction : fl
    task ins(input asf_op_t o, input logic [7:0] x, input logic [7:0] y,
             input logic [2:0] c, input logic [7:0] d);
        logic [7:0] xs;
        xs = c[2] ? st : x;
        u_core.issue(o, x, y, c, d);
        @(posedge mclk_in);
        #1;
        if (o != ASF_OP_NONE) st = {3'h0, fl(o, xs, y, st[4:0])};
        else if (c[1] && c[0]) st = {3'h0, d[4:0]};
        ck({24'h00_0000, stat}, {24'h00_0000, st});
    endtask : ins
    // ********
    // Sequence
    // ********
    initial begin
        repeat (5) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        apb(1'b0, 12'h000, 32'h0000_0000);
        ck(rd, 32'h0000_0000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        ck(rd, 32'h0000_001F);
        ins(ASF_OP_ADD, 8'h7F, 8'h01, 3'h0, 8'h00);
        ins(ASF_OP_ADD, 8'hFF, 8'h01, 3'h0, 8'h00);
        ins(ASF_OP_SUB, 8'h00, 8'h01, 3'h0, 8'h00);
        ins(ASF_OP_SUB, 8'h80, 8'h01, 3'h0, 8'h00);
        ins(ASF_OP_SUB, 8'h05, 8'h05, 3'h0, 8'h00);
        ins(ASF_OP_LOGIC, 8'hF0, 8'h0F, 3'h0, 8'h00);
        ins(ASF_OP_NONE, 8'h00, 8'h00, 3'h3, 8'hFF);
        ins(ASF_OP_NONE, 8'h00, 8'h00, 3'h3, 8'h0B);
        ins(ASF_OP_CLEAR, 8'h00, 8'h00, 3'h3, 8'h00);
        ins(ASF_OP_ADD, 8'h00, 8'h01, 3'h7, 8'hFF);
        ck({24'h00_0000, res}, 32'h0000_0010);
        apb(1'b0, 12'h000, 32'h0000_0000);
        ck(rd, {24'h00_0000, st});
        apb(1'b0, 12'h004, 32'h0000_0000);
        ck(rd, 32'h0000_0010);
        ins(ASF_OP_NONE, 8'h00, 8'h00, 3'h4, 8'h00);
        ck({24'h00_0000, res}, {24'h00_0000, st});
        apb(1'b0, 12'h00C, 32'h0000_0000);
        ck(rd, 32'h0000_0000);
        ck({31'h0, er}, 32'h0000_0001);
        apb(1'b1, 12'h008, 32'h0000_0000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        ck(rd, 32'h0000_0000);
        // All flags masked out: result moves, status must not
        u_core.issue(ASF_OP_ADD, 8'hFF, 8'h01, 3'h0, 8'h00);
        @(posedge mclk_in);
        #1;
        ck({24'h00_0000, stat}, {24'h00_0000, st});
        ck({24'h00_0000, res}, 32'h0000_0000);
        give_verdict;
    end
endmodule : testbench
